// ### logic/isf_defines.svh
// register offsets, bit positions and reset values of the status block
`ifndef ISF_DEFINES_SVH
`define ISF_DEFINES_SVH

`define ISF_OFF_CTRL_ONE 8'h00
`define ISF_OFF_CTRL_TWO 8'h04
`define ISF_OFF_DATA 8'h10
`define ISF_OFF_STAT_ONE 8'h14
`define ISF_OFF_STAT_TWO 8'h18

`define ISF_BIT_START 0
`define ISF_BIT_MATCH 1
`define ISF_BIT_BYTE_DONE 2
`define ISF_BIT_TEN_HDR 3
`define ISF_BIT_STOP 4
`define ISF_BIT_RX_FULL 6
`define ISF_BIT_TX_EMPTY 7
`define ISF_BIT_BUS_ERR 8
`define ISF_BIT_ARB_LOST 9
`define ISF_BIT_ACK_FAIL 10
`define ISF_BIT_OVERRUN 11
`define ISF_BIT_PEC_ERR 12

`define ISF_CR1_MODULE_ON 0
`define ISF_CR1_ACK_EN 10
`define ISF_CR1_STRETCH_DIS 7
`define ISF_CR2_ERR_IRQ 8
`define ISF_CR2_BUF_IRQ 10

`define ISF_RST_WORD 16'h0000
`define ISF_RST_BYTE 8'h00
`define ISF_RST_FLAG 1'b0

`endif

// ### logic/isf_pkg.sv
// types shared by the status-flag block
package isf_pkg;
    typedef enum logic [2:0] {
        ISF_ACC_IDLE = 3'b001,
        ISF_ACC_SR1 = 3'b010,
        ISF_ACC_SR1_SR2 = 3'b100
    } isf_seq_t;
endpackage : isf_pkg

// ### logic/isf_status_flags.sv
// status register one of an i2c controller with its set and clear logic
`timescale 1ns/1ps
`include "isf_defines.svh"

module isf_status_flags (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic ev_start_sent,
    input wire logic ev_addr_done,
    input wire logic ev_ten_hdr_sent,
    input wire logic ev_stop_seen,
    input wire logic ev_start_or_stop,
    input wire logic ev_byte_rx,
    input wire logic [7:0] rx_byte,
    input wire logic ev_byte_tx,
    input wire logic ev_nack_rx,
    input wire logic ev_arb_lost,
    input wire logic ev_bus_error,
    input wire logic ev_pec_bad,
    input wire logic is_master,
    input wire logic [15:0] status_two_in,
    output logic [7:0] tx_byte,
    output logic send_nak,
    output logic module_on,
    output logic stretch_disable,
    output logic err_irq,
    output logic evt_irq
);
    import isf_pkg::*;

    logic [15:0] ctrl_one;
    logic [15:0] ctrl_two;
    logic [7:0] data_reg;
    logic start_sent_flag;
    logic station_match_flag;
    logic byte_done_flag;
    logic ten_bit_header_flag;
    logic stop_seen_flag;
    logic rx_full_flag;
    logic tx_empty_flag;
    logic bus_error_flag;
    logic arb_lost_flag;
    logic ack_fail_flag;
    logic overrun_flag;
    logic pec_mismatch_flag;
    isf_seq_t seq;
    isf_seq_t next_seq;
    logic [15:0] next_rdata;
    logic [15:0] status_one;
    logic any_access;
    logic flags_off;
    logic clr_bus_err;
    logic clr_arb_lost;
    logic clr_ack_fail;
    logic clr_overrun;
    logic clr_pec;
    logic clr_match;
    logic clr_start;
    logic clr_ten_hdr;
    logic clr_stop;
    logic clr_rx_full;
    logic clr_tx_empty;
    logic set_start;
    logic set_ten_hdr;
    logic set_stop;
    logic set_tx_empty;
    logic next_bus_error;
    logic next_arb_lost;
    logic next_ack_fail;
    logic next_overrun;
    logic next_pec_mismatch;
    logic next_station_match;
    logic next_start_sent;
    logic next_ten_bit_header;
    logic next_stop_seen;
    logic next_byte_done;
    logic next_rx_full;
    logic next_tx_empty;

    // set beats clear, so an event landing with a clear is never lost
    function automatic logic hold_flag(input logic flag, input logic ev_in,
                                       input logic clr_in);
        hold_flag = ev_in | (flag & ~clr_in);
    endfunction : hold_flag

    // a status-one write clears a bit only where that bit is written 0
    function automatic logic zero_write(input logic wr, input logic wbit);
        zero_write = wr & ~wbit;
    endfunction : zero_write

    wire sel_c1 = reg_addr == `ISF_OFF_CTRL_ONE;
    wire sel_c2 = reg_addr == `ISF_OFF_CTRL_TWO;
    wire sel_dr = reg_addr == `ISF_OFF_DATA;
    wire sel_s1 = reg_addr == `ISF_OFF_STAT_ONE;
    wire sel_s2 = reg_addr == `ISF_OFF_STAT_TWO;
    wire wr_c1 = reg_write & sel_c1;
    wire wr_c2 = reg_write & sel_c2;
    wire wr_dr = reg_write & sel_dr;
    wire rd_dr = reg_read & sel_dr;
    wire wr_s1 = reg_write & sel_s1;
    wire rd_s1 = reg_read & sel_s1;
    wire rd_s2 = reg_read & sel_s2;
    wire after_s1 = seq == ISF_ACC_SR1;
    wire ack_en = ctrl_one[`ISF_CR1_ACK_EN];

    assign module_on = ctrl_one[`ISF_CR1_MODULE_ON];
    assign stretch_disable = ctrl_one[`ISF_CR1_STRETCH_DIS];
    assign send_nak = pec_mismatch_flag;
    // unread data blocks a received byte only when stretching is off
    wire rx_drop = stretch_disable & ev_byte_rx & rx_full_flag;
    wire tx_under = stretch_disable & ev_byte_tx & tx_empty_flag;
    wire set_ovr = module_on & (rx_drop | tx_under);
    wire set_btf = module_on & ~stretch_disable &
                   ((ev_byte_tx & tx_empty_flag) |
                    (ev_byte_rx & rx_full_flag));
    wire rx_take = module_on & ev_byte_rx & ~rx_drop;
    wire clr_btf = (after_s1 & (rd_dr | wr_dr)) | ev_start_or_stop;

    // reserved bits stay zero from the default word
    always_comb begin
        status_one = `ISF_RST_WORD;
        status_one[`ISF_BIT_START] = start_sent_flag;
        status_one[`ISF_BIT_MATCH] = station_match_flag;
        status_one[`ISF_BIT_BYTE_DONE] = byte_done_flag;
        status_one[`ISF_BIT_TEN_HDR] = ten_bit_header_flag;
        status_one[`ISF_BIT_STOP] = stop_seen_flag;
        status_one[`ISF_BIT_RX_FULL] = rx_full_flag;
        status_one[`ISF_BIT_TX_EMPTY] = tx_empty_flag;
        status_one[`ISF_BIT_BUS_ERR] = bus_error_flag;
        status_one[`ISF_BIT_ARB_LOST] = arb_lost_flag;
        status_one[`ISF_BIT_ACK_FAIL] = ack_fail_flag;
        status_one[`ISF_BIT_OVERRUN] = overrun_flag;
        status_one[`ISF_BIT_PEC_ERR] = pec_mismatch_flag;
    end

    // read-then-access tracker; any other access breaks the sequence
    assign any_access = reg_read | reg_write;

    always_comb begin
        next_seq = seq;
        unique case (seq)
            ISF_ACC_IDLE: begin
                if (rd_s1) begin
                    next_seq = ISF_ACC_SR1;
                end
            end
            ISF_ACC_SR1: begin
                if (rd_s1) begin
                    next_seq = ISF_ACC_SR1;
                end else if (any_access) begin
                    next_seq = ISF_ACC_IDLE;
                end
            end
            ISF_ACC_SR1_SR2: begin
                next_seq = rd_s1 ? ISF_ACC_SR1 : ISF_ACC_IDLE;
            end
        endcase
    end

    assign next_rdata = sel_c1 ? ctrl_one :
                        sel_c2 ? ctrl_two :
                        sel_dr ? {8'h00, data_reg} :
                        sel_s1 ? status_one :
                        sel_s2 ? status_two_in : `ISF_RST_WORD;

    assign tx_byte = data_reg;
    assign err_irq = ctrl_two[`ISF_CR2_ERR_IRQ] & (bus_error_flag |
        arb_lost_flag | ack_fail_flag | overrun_flag |
        pec_mismatch_flag);
    assign evt_irq = ctrl_two[`ISF_CR2_BUF_IRQ] &
        (tx_empty_flag | rx_full_flag);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= `ISF_RST_WORD;
        end else begin
            // idle cycles read as zero so stale data never lingers
            reg_rdata <= reg_read ? next_rdata : `ISF_RST_WORD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            seq <= ISF_ACC_IDLE;
        end else begin
            seq <= next_seq;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_one <= `ISF_RST_WORD;
        end else if (wr_c1) begin
            ctrl_one <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_two <= `ISF_RST_WORD;
        end else if (wr_c2) begin
            ctrl_two <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            data_reg <= `ISF_RST_BYTE;
        end else if (wr_dr) begin
            data_reg <= reg_wdata[7:0];
        end else if (rx_take) begin
            data_reg <= rx_byte;
        end
    end

    assign flags_off = reset | ~module_on;

    // clears; the error bits take only a written 0, the match bit also a status-two read right after a status-one read
    assign clr_bus_err = zero_write(wr_s1, reg_wdata[`ISF_BIT_BUS_ERR]);
    assign clr_arb_lost = zero_write(wr_s1, reg_wdata[`ISF_BIT_ARB_LOST]);
    assign clr_ack_fail = zero_write(wr_s1, reg_wdata[`ISF_BIT_ACK_FAIL]);
    assign clr_overrun = zero_write(wr_s1, reg_wdata[`ISF_BIT_OVERRUN]);
    assign clr_pec = zero_write(wr_s1, reg_wdata[`ISF_BIT_PEC_ERR]);
    assign clr_match = zero_write(wr_s1, reg_wdata[`ISF_BIT_MATCH]) |
        (after_s1 & rd_s2);
    assign clr_start = after_s1 & wr_dr;
    assign clr_ten_hdr = after_s1 & wr_dr;
    assign clr_stop = after_s1 & wr_c1;
    assign clr_rx_full = rd_dr | wr_dr;
    assign clr_tx_empty = wr_dr | ev_start_or_stop;

    // master-only and slave-only events are masked here, not upstream
    assign set_start = ev_start_sent & is_master;
    assign set_ten_hdr = ev_ten_hdr_sent & is_master;
    assign set_stop = ev_stop_seen & ~is_master & ack_en;
    // a data write in the same cycle refills the register at once
    assign set_tx_empty = ev_byte_tx & ~wr_dr;

    assign next_bus_error = hold_flag(bus_error_flag, ev_bus_error,
        clr_bus_err);
    assign next_arb_lost = hold_flag(arb_lost_flag, ev_arb_lost,
        clr_arb_lost);
    assign next_ack_fail = hold_flag(ack_fail_flag, ev_nack_rx,
        clr_ack_fail);
    assign next_overrun = hold_flag(overrun_flag, set_ovr,
        clr_overrun);
    assign next_pec_mismatch = hold_flag(pec_mismatch_flag, ev_pec_bad,
        clr_pec);
    // master after last address ack, slave on own match
    assign next_station_match = hold_flag(station_match_flag, ev_addr_done,
        clr_match);
    assign next_start_sent = hold_flag(start_sent_flag, set_start,
        clr_start);
    assign next_ten_bit_header = hold_flag(ten_bit_header_flag, set_ten_hdr,
        clr_ten_hdr);
    assign next_stop_seen = hold_flag(stop_seen_flag, set_stop, clr_stop);
    assign next_byte_done = hold_flag(byte_done_flag, set_btf,
        clr_btf);
    assign next_rx_full = hold_flag(rx_full_flag, rx_take, clr_rx_full);
    assign next_tx_empty = hold_flag(tx_empty_flag, set_tx_empty,
        clr_tx_empty);

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            bus_error_flag <= `ISF_RST_FLAG;
        end else begin
            bus_error_flag <= next_bus_error;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            arb_lost_flag <= `ISF_RST_FLAG;
        end else begin
            arb_lost_flag <= next_arb_lost;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            ack_fail_flag <= `ISF_RST_FLAG;
        end else begin
            ack_fail_flag <= next_ack_fail;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            overrun_flag <= `ISF_RST_FLAG;
        end else begin
            overrun_flag <= next_overrun;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            pec_mismatch_flag <= `ISF_RST_FLAG;
        end else begin
            pec_mismatch_flag <= next_pec_mismatch;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            station_match_flag <= `ISF_RST_FLAG;
        end else begin
            station_match_flag <= next_station_match;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            start_sent_flag <= `ISF_RST_FLAG;
        end else begin
            start_sent_flag <= next_start_sent;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            ten_bit_header_flag <= `ISF_RST_FLAG;
        end else begin
            ten_bit_header_flag <= next_ten_bit_header;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            stop_seen_flag <= `ISF_RST_FLAG;
        end else begin
            stop_seen_flag <= next_stop_seen;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            byte_done_flag <= `ISF_RST_FLAG;
        end else begin
            byte_done_flag <= next_byte_done;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            rx_full_flag <= `ISF_RST_FLAG;
        end else begin
            rx_full_flag <= next_rx_full;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (flags_off) begin
            tx_empty_flag <= `ISF_RST_FLAG;
        end else begin
            tx_empty_flag <= next_tx_empty;
        end
    end

endmodule : isf_status_flags

// ### test/isf_monitor.sv
// assertions on the status flag block ports
`timescale 1ns/1ps
module isf_monitor (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic ev_byte_rx,
    input wire logic ev_pec_bad,
    input wire logic [7:0] tx_byte,
    input wire logic send_nak,
    input wire logic module_on,
    input wire logic stretch_disable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_st_wr;
        reg_write && reg_addr == 8'h14;
    endsequence
    // a fresh check error wins over a written-0 clear, so it is excluded
    sequence s_nak_live;
        send_nak && module_on && !ev_pec_bad;
    endsequence
    AST_PEC_SET: assert property (ev_pec_bad && module_on |=> send_nak)
        else $error("nak not raised");
    AST_PEC_HOLD: assert property (s_nak_live ##0 !reg_write |=> send_nak)
        else $error("nak dropped");
    AST_W1_KEEP: assert property (
        s_nak_live ##0 s_st_wr ##0 reg_wdata[12] |=> send_nak)
        else $error("one write cleared");
    AST_W0_CLR: assert property (
        s_nak_live ##0 s_st_wr ##0 !reg_wdata[12] |=> !send_nak)
        else $error("zero write kept");
    AST_OFF_CLR: assert property (!module_on && !ev_pec_bad |=> !send_nak)
        else $error("flag while off");
    AST_DATA_WR: assert property (
        reg_write && reg_addr == 8'h10 && !ev_byte_rx
        |=> tx_byte == $past(reg_wdata[7:0]))
        else $error("data write lost");
    AST_ON_BIT: assert property (
        reg_write && reg_addr == 8'h00 |=> module_on == $past(reg_wdata[0]))
        else $error("enable bit wrong");
    AST_NO_STR: assert property (
        reg_write && reg_addr == 8'h00 |=> stretch_disable == $past(reg_wdata[7]))
        else $error("stretch bit wrong");
endmodule : isf_monitor
bind isf_status_flags isf_monitor u_isf_monitor (.sys_clk, .reset,
    .reg_addr, .reg_wdata, .reg_write, .ev_byte_rx, .ev_pec_bad, .tx_byte,
    .send_nak, .module_on, .stretch_disable);

// ### test/isf_bus_peer.sv
// far-side bus devices, reduced to one event pulse per request
`timescale 1ns/1ps
module isf_bus_peer (
    input wire logic sys_clk,
    input wire logic req,
    input wire logic [3:0] pick,
    input wire logic [7:0] byte_in,
    output logic [10:0] ev,
    output logic [7:0] rx_byte
);
    // byte is only meaningful with its pulse, so it toggles otherwise
    always_ff @(posedge sys_clk) begin
        ev <= req ? 11'h001 << pick : 11'h000;
        rx_byte <= req ? byte_in : ~rx_byte;
    end
endmodule : isf_bus_peer

// ### test/tb_isf_status_flags.sv
// self-checking bench for the status flag block
`timescale 1ns/1ps
module tb_isf_status_flags;
    logic sys_clk, reset, reg_write, reg_read, req, is_master;
    logic [7:0] reg_addr, byte_in, rx_byte, tx_byte;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [3:0] pick;
    logic [10:0] ev;
    logic send_nak, module_on, stretch_disable, err_irq, evt_irq;
    int fails = 0, checks_done = 0, cyc = 0;
    // master, event index, status bit
    logic [8:0] rows [10] = '{9'h100, 9'h111, 9'h123, 9'h034, 9'h056,
        9'h067, 9'h07A, 9'h089, 9'h098, 9'h0AC};
    isf_bus_peer u_isf_bus_peer (.sys_clk, .req, .pick, .byte_in, .ev,
        .rx_byte);
    isf_status_flags u_isf_status_flags (.sys_clk, .reset, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .ev_start_sent(ev[0]), .ev_addr_done(ev[1]), .ev_ten_hdr_sent(ev[2]),
        .ev_stop_seen(ev[3]), .ev_start_or_stop(ev[4]), .ev_byte_rx(ev[5]),
        .rx_byte, .ev_byte_tx(ev[6]), .ev_nack_rx(ev[7]),
        .ev_arb_lost(ev[8]), .ev_bus_error(ev[9]), .ev_pec_bad(ev[10]),
        .is_master, .status_two_in(16'h0000), .tx_byte, .send_nak,
        .module_on, .stretch_disable, .err_irq, .evt_irq);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [7:0] a,
        input logic [15:0] w);
        @(posedge sys_clk);
        reg_write <= wr;
        reg_read <= !wr;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : acc
    task automatic bus_ev(input logic [3:0] p, input logic [7:0] b);
        @(posedge sys_clk);
        req <= 1'b1;
        pick <= p;
        byte_in <= b;
        @(posedge sys_clk);
        req <= 1'b0;
    endtask : bus_ev
    task automatic close_out();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        {reset, reg_write, reg_read, req, is_master} = 5'h10;
        {reg_addr, byte_in, pick, reg_wdata} = 36'h0;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        acc(0, 8'h14, 16'h0000);
        chk(d, 16'h0000);
        acc(1, 8'h00, 16'h0401);
        foreach (rows[i]) begin
            is_master <= rows[i][8];
            bus_ev(rows[i][7:4], 8'hC3);
            acc(0, 8'h14, 16'h0000);
            chk({15'h0000, d[rows[i][3:0]]}, 16'h0001);
        end
        acc(1, 8'h14, 16'hFFFF);
        acc(0, 8'h14, 16'h0000);
        chk(d & 16'h1702, 16'h1702);
        acc(0, 8'h18, 16'h0000);
        acc(0, 8'h14, 16'h0000);
        chk(d & 16'h0002, 16'h0000);
        acc(1, 8'h04, 16'h0500);
        chk({14'h0000, err_irq, evt_irq}, 16'h0003);
        acc(1, 8'h14, 16'h0000);
        acc(0, 8'h14, 16'h0000);
        chk({d[15:8], 7'h00, err_irq}, 16'h0000);
        acc(1, 8'h10, 16'h005A);
        acc(0, 8'h14, 16'h0000);
        chk(d & 16'h00CD, 16'h0000);
        acc(1, 8'h00, 16'h0401);
        acc(0, 8'h14, 16'h0000);
        chk({d[4], evt_irq, 6'h00, tx_byte}, 16'h005A);
        acc(1, 8'h00, 16'h0481);
        bus_ev(4'h5, 8'hA5);
        bus_ev(4'h5, 8'h3C);
        acc(0, 8'h14, 16'h0000);
        chk({d[11], err_irq, 6'h00, tx_byte}, 16'hC0A5);
        acc(1, 8'h14, 16'h0000);
        bus_ev(4'h6, 8'h00);
        bus_ev(4'h6, 8'h00);
        acc(0, 8'h14, 16'h0000);
        chk({d[11], 7'h00, tx_byte}, 16'h80A5);
        acc(1, 8'h00, 16'h0000);
        acc(0, 8'h14, 16'h0000);
        chk({d[15:1], module_on}, 16'h0000);
        acc(1, 8'h00, 16'h0401);
        bus_ev(4'h6, 8'h00);
        bus_ev(4'h6, 8'h00);
        acc(0, 8'h14, 16'h0000);
        chk(d & 16'h0084, 16'h0084);
        acc(1, 8'h10, 16'h0011);
        acc(0, 8'h14, 16'h0000);
        chk(d & 16'h0084, 16'h0000);
        bus_ev(4'h6, 8'h00);
        bus_ev(4'h6, 8'h00);
        bus_ev(4'h4, 8'h00);
        acc(0, 8'h14, 16'h0000);
        chk(d & 16'h0084, 16'h0000);
        bus_ev(4'h9, 8'h00);
        acc(0, 8'h14, 16'h0000);
        chk({15'h0000, d[8]}, 16'h0001);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        acc(0, 8'h14, 16'h0000);
        chk({d[15:1], module_on}, 16'h0000);
        acc(0, 8'h08, 16'h0000);
        chk(d, 16'h0000);
        close_out();
    end
endmodule : tb_isf_status_flags
